// file: hw/iorsd_decode.sv
`timescale 1ns/100ps
module iorsd_decode #(
	parameter int REG_SLOTS = 32
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	// Core operation request
	input  wire logic                 op_valid,
	input  wire iorsd_pkg::iorsd_op_type op_kind,
	input  wire logic [7:0]           op_addr,
	input  wire logic [7:0]           index_x,
	input  wire logic [7:0]           acc_wdata,
	// Accumulator answer
	output logic                      rd_valid_r,
	output logic      [7:0]           acc_rdata_r,
	// Mode and live status
	input  wire logic                 five_ep_mode,
	input  wire logic [7:0]           pend_vector_in,
	input  wire logic [7:0]           dp_resume_in,
	input  wire logic [7:0]           dp_se0_in,
	input  wire logic [7:0]           dp_lines_in,
	// Peripheral write strobe
	output logic                      per_wr_r,
	output logic      [7:0]           per_addr_r,
	output logic      [7:0]           per_wdata_r,
	// Endpoint setup target
	output logic                      ep_setup_wr_r,
	output logic                      ep_setup_second_r,
	output logic      [2:0]           ep_setup_num_r,
	// Side effects
	output logic                      vec_clear_r,
	output logic                      watchdog_restart_r
);
	import iorsd_pkg::*;

	localparam int SW = $clog2(REG_SLOTS);

	if (REG_SLOTS < IORSD_RW_COUNT) begin : g_chk
		$error("REG_SLOTS too small for the read-write registers");
	end

	// ************************************************
	// State
	// ************************************************
	typedef struct packed {
		logic [6:0]               tick_div;
		logic [IORSD_TIMER_W-1:0] tick_cnt;
		logic [3:0]               hi_hold;
		logic                     rd_pend;
		logic                     rd_from_mem;
		logic [7:0]               rd_imm;
		logic                     rd_valid;
		logic [7:0]               acc_rdata;
		logic                     per_wr;
		logic [7:0]               per_addr;
		logic [7:0]               per_wdata;
		logic                     ep_wr;
		logic                     ep_second;
		logic [2:0]               ep_num;
		logic                     vec_clear;
		logic                     wdog;
	} iorsd_state_type;

	iorsd_state_type st_r;
	iorsd_state_type st_nxt;

	logic [7:0]    eff_addr;
	logic          take_rd;
	logic          take_wr;
	logic          slot_hit;
	logic [SW-1:0] slot;
	logic [7:0]    mem_rdata;
	logic          wr_ok;

	// ************************************************
	// Address formation
	// ************************************************
	always_comb begin
		eff_addr = op_addr;
		take_rd  = 1'b0;
		take_wr  = 1'b0;
		unique case (op_kind)
			IORSD_OP_READ: begin
				take_rd = op_valid;
			end
			IORSD_OP_WRITE: begin
				take_wr = op_valid;
			end
			IORSD_OP_XWRITE: begin
				eff_addr = 8'(op_addr + index_x);
				take_wr  = op_valid;
			end
			default: begin
				eff_addr = op_addr;
			end
		endcase
	end

	// ************************************************
	// Read-write slot lookup
	// ************************************************
	always_comb begin
		slot_hit = 1'b1;
		slot     = '0;
		unique case (eff_addr)
			IORSD_A_P0_VALUE:       slot = SW'(0);
			IORSD_A_P1_VALUE:       slot = SW'(1);
			IORSD_A_PIN_SETUP:      slot = SW'(2);
			IORSD_A_TW_PIN_POS:     slot = SW'(3);
			IORSD_A_FIRST_ADDR:     slot = SW'(4);
			IORSD_A_FIRST_EP0_CNT:  slot = SW'(5);
			IORSD_A_FIRST_EP0_SET:  slot = SW'(6);
			IORSD_A_FIRST_EP1_CNT:  slot = SW'(7);
			IORSD_A_FIRST_EP1_SET:  slot = SW'(8);
			IORSD_A_FIRST_EP2_CNT:  slot = SW'(9);
			IORSD_A_FIRST_EP2_SET:  slot = SW'(10);
			IORSD_A_UP_TRAFFIC:     slot = SW'(11);
			IORSD_A_GLOBAL_MASK:    slot = SW'(12);
			IORSD_A_EP_MASK:        slot = SW'(13);
			IORSD_A_TW_CTRL:        slot = SW'(14);
			IORSD_A_TW_BYTE:        slot = SW'(15);
			IORSD_A_SECOND_ADDR: begin
				slot     = SW'(16);
				slot_hit = !five_ep_mode;
			end
			IORSD_A_SECOND_EP0_CNT: slot = SW'(17);
			IORSD_A_SECOND_EP0_SET: slot = SW'(18);
			IORSD_A_SECOND_EP1_CNT: slot = SW'(19);
			IORSD_A_SECOND_EP1_SET: slot = SW'(20);
			IORSD_A_DP_ATTACH:      slot = SW'(21);
			IORSD_A_DP_ENABLES:     slot = SW'(22);
			IORSD_A_DP_SPEED:       slot = SW'(23);
			IORSD_A_DP_DRIVE:       slot = SW'(24);
			IORSD_A_DP_SUSPEND:     slot = SW'(25);
			IORSD_A_DP_PULL_LOW:    slot = SW'(26);
			IORSD_A_CPU_STATE:      slot = SW'(27);
			default:                slot_hit = 1'b0;
		endcase
	end

	// Write-only addresses pass to the peripherals but are not stored
	always_comb begin
		wr_ok = slot_hit;
		if (eff_addr == IORSD_A_P0_IRQ_MASK || eff_addr == IORSD_A_P1_IRQ_MASK ||
			eff_addr == IORSD_A_WDOG_KICK) begin
			wr_ok = 1'b1;
		end
	end

	iorsd_reg_store #(
		.DEPTH (REG_SLOTS),
		.AW    (SW),
		.DW    (IORSD_DATA_W)
	) u_store (
		.clk       (clk),
		.reset_n   (reset_n),
		.wr_en     (take_wr && slot_hit),
		.wr_slot   (slot),
		.wr_data   (acc_wdata),
		.rd_slot   (slot),
		.rd_data_r (mem_rdata)
	);

	// ************************************************
	// Next state
	// ************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.per_wr    = 1'b0;
		st_nxt.ep_wr     = 1'b0;
		st_nxt.vec_clear = 1'b0;
		st_nxt.wdog      = 1'b0;
		st_nxt.rd_pend   = 1'b0;
		st_nxt.rd_valid  = 1'b0;

		// Free-running tick count
		if (st_r.tick_div == 7'(IORSD_TICK_CYCLES - 1)) begin
			st_nxt.tick_div = '0;
			st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
		end else begin
			st_nxt.tick_div = st_r.tick_div + 1'b1;
		end

		// Second stage of a read
		if (st_r.rd_pend) begin
			st_nxt.rd_valid  = 1'b1;
			st_nxt.acc_rdata = st_r.rd_from_mem ? mem_rdata : st_r.rd_imm;
		end

		// First stage of a read
		if (take_rd) begin
			st_nxt.rd_pend     = 1'b1;
			st_nxt.rd_from_mem = 1'b0;
			st_nxt.rd_imm      = IORSD_ZERO_BYTE;
			unique case (eff_addr)
				IORSD_A_PEND_VECTOR: begin
					st_nxt.rd_imm    = pend_vector_in;
					st_nxt.vec_clear = 1'b1;
				end
				IORSD_A_TICK_LOW: begin
					st_nxt.rd_imm  = st_r.tick_cnt[7:0];
					st_nxt.hi_hold = st_r.tick_cnt[11:8];
				end
				IORSD_A_TICK_HIGH: begin
					st_nxt.rd_imm = {IORSD_HI_PAD, st_r.hi_hold};
				end
				IORSD_A_DP_RESUME: st_nxt.rd_imm = dp_resume_in;
				IORSD_A_DP_SE0:    st_nxt.rd_imm = dp_se0_in;
				IORSD_A_DP_LINES:  st_nxt.rd_imm = dp_lines_in;
				default: begin
					st_nxt.rd_from_mem = slot_hit;
				end
			endcase
		end

		// Writes
		if (take_wr && wr_ok) begin
			st_nxt.per_wr    = 1'b1;
			st_nxt.per_addr  = eff_addr;
			st_nxt.per_wdata = acc_wdata;
			if (eff_addr == IORSD_A_WDOG_KICK) begin
				st_nxt.wdog = 1'b1;
			end
			unique case (eff_addr)
				IORSD_A_FIRST_EP0_SET: begin
					st_nxt.ep_wr     = 1'b1;
					st_nxt.ep_second = 1'b0;
					st_nxt.ep_num    = IORSD_EP0;
				end
				IORSD_A_FIRST_EP1_SET: begin
					st_nxt.ep_wr     = 1'b1;
					st_nxt.ep_second = 1'b0;
					st_nxt.ep_num    = IORSD_EP1;
				end
				IORSD_A_FIRST_EP2_SET: begin
					st_nxt.ep_wr     = 1'b1;
					st_nxt.ep_second = 1'b0;
					st_nxt.ep_num    = IORSD_EP2;
				end
				IORSD_A_SECOND_EP0_SET: begin
					st_nxt.ep_wr     = 1'b1;
					st_nxt.ep_second = !five_ep_mode;
					st_nxt.ep_num    = five_ep_mode ? IORSD_EP3 : IORSD_EP0;
				end
				IORSD_A_SECOND_EP1_SET: begin
					st_nxt.ep_wr     = 1'b1;
					st_nxt.ep_second = !five_ep_mode;
					st_nxt.ep_num    = five_ep_mode ? IORSD_EP4 : IORSD_EP1;
				end
				default: begin
					st_nxt.ep_wr = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	assign rd_valid_r         = st_r.rd_valid;
	assign acc_rdata_r        = st_r.acc_rdata;
	assign per_wr_r           = st_r.per_wr;
	assign per_addr_r         = st_r.per_addr;
	assign per_wdata_r        = st_r.per_wdata;
	assign ep_setup_wr_r      = st_r.ep_wr;
	assign ep_setup_second_r  = st_r.ep_second;
	assign ep_setup_num_r     = st_r.ep_num;
	assign vec_clear_r        = st_r.vec_clear;
	assign watchdog_restart_r = st_r.wdog;

	// ************************************************
	// Checks
	// ************************************************
	property p_read_answer;
		@(posedge clk) disable iff (!reset_n) take_rd |-> ##2 rd_valid_r;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("Read answer late");

	property p_read_only;
		@(posedge clk) disable iff (!reset_n) rd_valid_r |-> $past(take_rd, 2);
	endproperty
	a_read_only: assert property (p_read_only) else $error("Answer without a read");

	property p_write_strobe;
		@(posedge clk) disable iff (!reset_n)
			(take_wr && slot_hit) |=> per_wr_r && per_wdata_r == $past(acc_wdata);
	endproperty
	a_write_strobe: assert property (p_write_strobe) else $error("Write lost");

	property p_index_sum;
		@(posedge clk) disable iff (!reset_n) (take_wr && wr_ok && op_kind == IORSD_OP_XWRITE)
			|=> per_addr_r == 8'($past(op_addr) + $past(index_x));
	endproperty
	a_index_sum: assert property (p_index_sum) else $error("Indexed address wrong");

	property p_index_zero;
		@(posedge clk) disable iff (!reset_n)
			(take_wr && wr_ok && op_kind == IORSD_OP_XWRITE && op_addr == 8'h00)
			|=> per_addr_r == $past(index_x);
	endproperty
	a_index_zero: assert property (p_index_zero) else $error("Index-only address wrong");

	property p_tick_low;
		@(posedge clk) disable iff (!reset_n) (take_rd && eff_addr == IORSD_A_TICK_LOW)
			|-> ##2 acc_rdata_r == $past(st_r.tick_cnt[7:0], 2);
	endproperty
	a_tick_low: assert property (p_tick_low) else $error("Low tick byte wrong");

	property p_tick_high;
		@(posedge clk) disable iff (!reset_n) (take_rd && eff_addr == IORSD_A_TICK_HIGH)
			|-> ##2 acc_rdata_r == {IORSD_HI_PAD, $past(st_r.hi_hold)};
	endproperty
	a_tick_high: assert property (p_tick_high) else $error("High tick nibble wrong");

	property p_hold_capture;
		@(posedge clk) disable iff (!reset_n) (take_rd && eff_addr == IORSD_A_TICK_LOW)
			|=> st_r.hi_hold == $past(st_r.tick_cnt[11:8]);
	endproperty
	a_hold_capture: assert property (p_hold_capture) else $error("Nibble not frozen");

	property p_vec_clear;
		@(posedge clk) disable iff (!reset_n) (take_rd && eff_addr == IORSD_A_PEND_VECTOR)
			|=> vec_clear_r ##1 (rd_valid_r && acc_rdata_r == $past(pend_vector_in, 2));
	endproperty
	a_vec_clear: assert property (p_vec_clear) else $error("Vector read wrong");

	property p_mask_wo;
		@(posedge clk) disable iff (!reset_n) (take_rd && eff_addr == IORSD_A_P0_IRQ_MASK)
			|-> ##2 acc_rdata_r == IORSD_ZERO_BYTE;
	endproperty
	a_mask_wo: assert property (p_mask_wo) else $error("Write-only mask readable");

	property p_second_addr_off;
		@(posedge clk) disable iff (!reset_n)
			(take_wr && five_ep_mode && eff_addr == IORSD_A_SECOND_ADDR) |=> !per_wr_r;
	endproperty
	a_second_addr_off: assert property (p_second_addr_off) else $error("Second address live");

	property p_ep3;
		@(posedge clk) disable iff (!reset_n)
			(take_wr && five_ep_mode && eff_addr == IORSD_A_SECOND_EP0_SET)
			|=> ep_setup_wr_r && !ep_setup_second_r && ep_setup_num_r == IORSD_EP3;
	endproperty
	a_ep3: assert property (p_ep3) else $error("Endpoint 3 alias wrong");

	property p_ep4;
		@(posedge clk) disable iff (!reset_n)
			(take_wr && five_ep_mode && eff_addr == IORSD_A_SECOND_EP1_SET)
			|=> ep_setup_wr_r && !ep_setup_second_r && ep_setup_num_r == IORSD_EP4;
	endproperty
	a_ep4: assert property (p_ep4) else $error("Endpoint 4 alias wrong");

	property p_ro_drop;
		@(posedge clk) disable iff (!reset_n) (take_wr && (eff_addr == IORSD_A_DP_SE0 ||
			eff_addr == IORSD_A_DP_LINES || eff_addr == IORSD_A_DP_RESUME)) |=> !per_wr_r;
	endproperty
	a_ro_drop: assert property (p_ro_drop) else $error("Read-only register written");

	property p_rsvd;
		@(posedge clk) disable iff (!reset_n) (take_rd && !slot_hit && eff_addr == 8'h30)
			|-> ##2 acc_rdata_r == IORSD_ZERO_BYTE;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("Reserved read not zero");

	c_indexed: cover property (@(posedge clk) disable iff (!reset_n)
		take_wr && op_kind == IORSD_OP_XWRITE);
	c_tick_pair: cover property (@(posedge clk) disable iff (!reset_n)
		(take_rd && eff_addr == IORSD_A_TICK_LOW) ##[1:8]
		(take_rd && eff_addr == IORSD_A_TICK_HIGH));
	c_five_ep: cover property (@(posedge clk) disable iff (!reset_n)
		ep_setup_wr_r && ep_setup_num_r == IORSD_EP4);

endmodule : iorsd_decode

// file: hw/iorsd_pkg.sv
package iorsd_pkg;

	// ************************************************
	// Register offsets
	// ************************************************
	localparam logic [7:0] IORSD_A_P0_VALUE     = 8'h00;
	localparam logic [7:0] IORSD_A_P1_VALUE     = 8'h01;
	localparam logic [7:0] IORSD_A_P0_IRQ_MASK  = 8'h04;
	localparam logic [7:0] IORSD_A_P1_IRQ_MASK  = 8'h05;
	localparam logic [7:0] IORSD_A_PIN_SETUP    = 8'h08;
	localparam logic [7:0] IORSD_A_TW_PIN_POS   = 8'h09;
	localparam logic [7:0] IORSD_A_FIRST_ADDR   = 8'h10;
	localparam logic [7:0] IORSD_A_FIRST_EP0_CNT = 8'h11;
	localparam logic [7:0] IORSD_A_FIRST_EP0_SET = 8'h12;
	localparam logic [7:0] IORSD_A_FIRST_EP1_CNT = 8'h13;
	localparam logic [7:0] IORSD_A_FIRST_EP1_SET = 8'h14;
	localparam logic [7:0] IORSD_A_FIRST_EP2_CNT = 8'h15;
	localparam logic [7:0] IORSD_A_FIRST_EP2_SET = 8'h16;
	localparam logic [7:0] IORSD_A_UP_TRAFFIC   = 8'h1f;
	localparam logic [7:0] IORSD_A_GLOBAL_MASK  = 8'h20;
	localparam logic [7:0] IORSD_A_EP_MASK      = 8'h21;
	localparam logic [7:0] IORSD_A_PEND_VECTOR  = 8'h23;
	localparam logic [7:0] IORSD_A_TICK_LOW     = 8'h24;
	localparam logic [7:0] IORSD_A_TICK_HIGH    = 8'h25;
	localparam logic [7:0] IORSD_A_WDOG_KICK    = 8'h26;
	localparam logic [7:0] IORSD_A_TW_CTRL      = 8'h28;
	localparam logic [7:0] IORSD_A_TW_BYTE      = 8'h29;
	localparam logic [7:0] IORSD_A_SECOND_ADDR  = 8'h40;
	localparam logic [7:0] IORSD_A_SECOND_EP0_CNT = 8'h41;
	localparam logic [7:0] IORSD_A_SECOND_EP0_SET = 8'h42;
	localparam logic [7:0] IORSD_A_SECOND_EP1_CNT = 8'h43;
	localparam logic [7:0] IORSD_A_SECOND_EP1_SET = 8'h44;
	localparam logic [7:0] IORSD_A_DP_ATTACH    = 8'h48;
	localparam logic [7:0] IORSD_A_DP_ENABLES   = 8'h49;
	localparam logic [7:0] IORSD_A_DP_SPEED     = 8'h4a;
	localparam logic [7:0] IORSD_A_DP_DRIVE     = 8'h4b;
	localparam logic [7:0] IORSD_A_DP_SUSPEND   = 8'h4d;
	localparam logic [7:0] IORSD_A_DP_RESUME    = 8'h4e;
	localparam logic [7:0] IORSD_A_DP_SE0       = 8'h4f;
	localparam logic [7:0] IORSD_A_DP_LINES     = 8'h50;
	localparam logic [7:0] IORSD_A_DP_PULL_LOW  = 8'h51;
	localparam logic [7:0] IORSD_A_CPU_STATE    = 8'hff;

	// ************************************************
	// Sizes, fields and reset values
	// ************************************************
	localparam int         IORSD_DATA_W     = 8;
	localparam int         IORSD_RW_COUNT   = 28;
	localparam int         IORSD_TIMER_W    = 12;
	localparam logic [7:0] IORSD_ZERO_BYTE  = 8'h00;
	localparam logic [3:0] IORSD_HI_PAD     = 4'h0;
	localparam logic [2:0] IORSD_EP0        = 3'h0;
	localparam logic [2:0] IORSD_EP1        = 3'h1;
	localparam logic [2:0] IORSD_EP2        = 3'h2;
	localparam logic [2:0] IORSD_EP3        = 3'h3;
	localparam logic [2:0] IORSD_EP4        = 3'h4;

	// ************************************************
	// Timing
	// ************************************************
	localparam int IORSD_CLK_PERIOD_NS  = 8;
	localparam int IORSD_TICK_PERIOD_NS = 1000;
	localparam int IORSD_TICK_CYCLES    = IORSD_TICK_PERIOD_NS / IORSD_CLK_PERIOD_NS;

	// ************************************************
	// Core operations
	// ************************************************
	typedef enum logic [2:0] {
		IORSD_OP_READ   = 3'b001,
		IORSD_OP_WRITE  = 3'b010,
		IORSD_OP_XWRITE = 3'b100
	} iorsd_op_type;

endpackage : iorsd_pkg

// file: hw/iorsd_reg_store.sv
`timescale 1ns/100ps
module iorsd_reg_store #(
	parameter int DEPTH = 32,
	parameter int AW    = 5,
	parameter int DW    = 8
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          reset_n,
	// Write port
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_slot,
	input  wire logic [DW-1:0] wr_data,
	// Read port
	input  wire logic [AW-1:0] rd_slot,
	output logic      [DW-1:0] rd_data_r
);
	import iorsd_pkg::*;

	if (DEPTH > (1 << AW)) begin : g_chk
		$error("Store depth exceeds slot address range");
	end

	typedef struct packed {
		logic [DEPTH-1:0][DW-1:0] cells;
		logic [DW-1:0]            rdata;
	} iorsd_store_type;

	iorsd_store_type st_r;
	iorsd_store_type st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = st_r.cells[rd_slot];
		if (wr_en) begin
			st_nxt.cells[wr_slot] = wr_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_data_r = st_r.rdata;

endmodule : iorsd_reg_store

// file: verif/iorsd_core_model.sv
`timescale 1ns/100ps
module iorsd_core_model (
	// Clock
	input  wire logic               clk,
	// Request to the decoder
	output logic                    op_valid,
	output iorsd_pkg::iorsd_op_type op_kind,
	output logic [7:0]              op_addr,
	output logic [7:0]              index_x,
	output logic [7:0]              acc_wdata
);
	import iorsd_pkg::*;

	// Bit positions kept clear on every write
	localparam logic [7:0] RSVD_BITS = 8'h00;

	initial begin
		op_valid  = 1'b0;
		op_kind   = IORSD_OP_READ;
		op_addr   = 8'h00;
		index_x   = 8'h00;
		acc_wdata = 8'h00;
	end

	// One operation after gap idle cycles, none for a non-read to 8'h30..8'h3f unless rogue; entered just after a rising edge
	task automatic issue(input iorsd_op_type k, input logic [7:0] a, x, d,
		input int gap, input bit rogue);
		repeat (gap) begin
			@(posedge clk);
			#1;
		end
		if (k != IORSD_OP_READ && a >= 8'h30 && a <= 8'h3f && !rogue) begin
			return;
		end
		op_valid  = 1'b1;
		op_kind   = k;
		op_addr   = a;
		index_x   = x;
		acc_wdata = d & ~RSVD_BITS;
		@(posedge clk);
		#1;
		// Released lines no longer show the last value
		op_valid  = 1'b0;
		op_addr   = ~op_addr;
		index_x   = ~index_x;
		acc_wdata = ~acc_wdata;
	endtask : issue
endmodule : iorsd_core_model

// file: verif/test_io_register_space_decode.sv
`timescale 1ns/100ps
module test_io_register_space_decode;
	import iorsd_pkg::*;

	// ****************************
	// Signals
	// ****************************
	logic         clk, reset_n, op_valid, five_ep_mode;
	iorsd_op_type op_kind;
	logic [7:0]   op_addr, index_x, acc_wdata, acc_rdata_r, pend_vector_in;
	logic [7:0]   dp_resume_in, dp_se0_in, dp_lines_in, per_addr_r, per_wdata_r;
	logic         rd_valid_r, per_wr_r, ep_setup_wr_r, ep_setup_second_r;
	logic         vec_clear_r, watchdog_restart_r;
	logic [2:0]   ep_setup_num_r;
	logic [4:0]   strb;
	logic [7:0]   s_ad, s_da, s_rd;
	logic [2:0]   s_num;
	logic         s_sec, s_rv;
	int           cyc = 0;
	int           c0, compares, bad_count;
	localparam iorsd_op_type RD = IORSD_OP_READ;
	localparam iorsd_op_type WR = IORSD_OP_WRITE;
	localparam iorsd_op_type XW = IORSD_OP_XWRITE;
	logic [7:0] rw_list [IORSD_RW_COUNT] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h10, 8'h11,
		8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h1f, 8'h20, 8'h21, 8'h28, 8'h29, 8'h40,
		8'h41, 8'h42, 8'h43, 8'h44, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4d, 8'h51, 8'hff};
	logic [7:0] ro_list [12] = '{8'h23, 8'h24, 8'h25, 8'h4e, 8'h4f, 8'h50, 8'h30, 8'h31,
		8'h32, 8'h38, 8'h3f, 8'h02};
	logic [7:0] ix_list [3][3] = '{'{8'h10, 8'h11, 8'h21}, '{8'h00, 8'h29, 8'h29},
		'{8'hf0, 8'h10, 8'h00}};
	logic [7:0] wo_list [3] = '{8'h04, 8'h05, 8'h26};

	iorsd_decode u_iorsd_decode (
		.clk                (clk),
		.reset_n            (reset_n),
		.op_valid           (op_valid),
		.op_kind            (op_kind),
		.op_addr            (op_addr),
		.index_x            (index_x),
		.acc_wdata          (acc_wdata),
		.rd_valid_r         (rd_valid_r),
		.acc_rdata_r        (acc_rdata_r),
		.five_ep_mode       (five_ep_mode),
		.pend_vector_in     (pend_vector_in),
		.dp_resume_in       (dp_resume_in),
		.dp_se0_in          (dp_se0_in),
		.dp_lines_in        (dp_lines_in),
		.per_wr_r           (per_wr_r),
		.per_addr_r         (per_addr_r),
		.per_wdata_r        (per_wdata_r),
		.ep_setup_wr_r      (ep_setup_wr_r),
		.ep_setup_second_r  (ep_setup_second_r),
		.ep_setup_num_r     (ep_setup_num_r),
		.vec_clear_r        (vec_clear_r),
		.watchdog_restart_r (watchdog_restart_r)
	);

	iorsd_core_model u_iorsd_core_model (
		.clk       (clk),
		.op_valid  (op_valid),
		.op_kind   (op_kind),
		.op_addr   (op_addr),
		.index_x   (index_x),
		.acc_wdata (acc_wdata)
	);

	// ****************************
	// Clock, cycle count, time limit
	// ****************************
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	initial begin
		#(IORSD_CLK_PERIOD_NS * 100000);
		bad_count++;
		final_report;
	end

	// ****************************
	// Helpers
	// ****************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Strobes {read valid, write, setup, vector clear, watchdog} seen in cycle 1
	task automatic op(input iorsd_op_type k, input logic [7:0] a, x, d, input bit rogue);
		u_iorsd_core_model.issue(k, a, x, d, rogue ? 2 : 0, rogue);
		strb = {rd_valid_r, per_wr_r, ep_setup_wr_r, vec_clear_r, watchdog_restart_r};
		s_ad = per_addr_r;
		s_da = per_wdata_r;
		s_sec = ep_setup_second_r;
		s_num = ep_setup_num_r;
		@(posedge clk);
		#1;
		s_rv = rd_valid_r;
		s_rd = acc_rdata_r;
	endtask : op

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		op(RD, a, 8'h00, 8'h00, 1'b0);
		chk({3'h0, strb[4], 3'h0, s_rv}, 8'h01);
		chk(s_rd, exp);
	endtask : rd

	task automatic wait_until(input int t);
		while (cyc < t) begin
			@(posedge clk);
			#1;
		end
	endtask : wait_until

	// ****************************
	// Scenarios
	// ****************************
	task automatic t_rw;
		logic [7:0] a;
		logic       e;
		for (int i = 0; i < IORSD_RW_COUNT; i++) begin
			a = rw_list[i];
			e = a inside {8'h12, 8'h14, 8'h16, 8'h42, 8'h44};
			op(WR, a, 8'h00, a ^ 8'ha5, 1'b0);
			chk({3'h0, strb}, {4'h0, 1'b1, e, 2'h0});
			chk(s_ad, a);
			chk(s_da, a ^ 8'ha5);
			if (e) begin
				chk({s_sec, 4'h0, s_num}, {a[6], 4'h0, 3'((a - (a[6] ? 8'h42 : 8'h12)) >> 1)});
			end
			rd(a, a ^ 8'ha5);
		end
	endtask : t_rw

	task automatic t_idx;
		for (int i = 0; i < 3; i++) begin
			op(XW, ix_list[i][0], ix_list[i][1], 8'hc3, 1'b0);
			chk({3'h0, strb}, 8'h08);
			chk(s_ad, ix_list[i][2]);
			rd(ix_list[i][2], 8'hc3);
		end
	endtask : t_idx

	task automatic t_wo;
		for (int i = 0; i < 3; i++) begin
			op(WR, wo_list[i], 8'h00, 8'h3c, 1'b0);
			chk({3'h0, strb}, 8'h08 | {7'h0, wo_list[i] == 8'h26});
			rd(wo_list[i], 8'h00);
		end
	endtask : t_wo

	task automatic t_refuse;
		dp_resume_in = 8'h81;
		dp_se0_in    = 8'h42;
		dp_lines_in  = 8'h17;
		for (int i = 0; i < 12; i++) begin
			op(WR, ro_list[i], 8'h00, 8'hff, 1'b1);
			chk({3'h0, strb}, 8'h00);
		end
		for (int i = 6; i < 12; i++) begin
			rd(ro_list[i], 8'h00);
		end
		rd(8'h4e, 8'h81);
		rd(8'h4f, 8'h42);
		rd(8'h50, 8'h17);
	endtask : t_refuse

	task automatic t_vec;
		pend_vector_in = 8'h3c;
		op(RD, 8'h23, 8'h00, 8'h00, 1'b0);
		chk({3'h0, strb}, 8'h02);
		chk(s_rd, 8'h3c);
		chk({7'h0, s_rv}, 8'h01);
		op(RD, 8'h4e, 8'h00, 8'h00, 1'b0);
		chk({3'h0, strb}, 8'h00);
		chk(s_rd, 8'h81);
	endtask : t_vec

	task automatic t_five;
		five_ep_mode = 1'b1;
		op(WR, 8'h42, 8'h00, 8'h11, 1'b0);
		chk({3'h0, strb}, 8'h0c);
		chk({4'h0, s_sec, s_num}, 8'h03);
		op(WR, 8'h44, 8'h00, 8'h22, 1'b0);
		chk({3'h0, strb}, 8'h0c);
		chk({4'h0, s_sec, s_num}, 8'h04);
		op(WR, 8'h40, 8'h00, 8'h7e, 1'b0);
		chk({3'h0, strb}, 8'h00);
		rd(8'h40, 8'h00);
		five_ep_mode = 1'b0;
		rd(8'h40, 8'he5);
	endtask : t_five

	task automatic t_timer_a;
		c0 = cyc;
		rd(8'h24, 8'h00);
		rd(8'h25, 8'h00);
	endtask : t_timer_a

	task automatic t_timer_b;
		wait_until(c0 + 125 * 300);
		rd(8'h24, 8'h2c);
		rd(8'h25, 8'h01);
		wait_until(c0 + 125 * 560);
		rd(8'h25, 8'h01);
	endtask : t_timer_b

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	// ****************************
	// Main sequence
	// ****************************
	initial begin
		compares       = 0;
		bad_count      = 0;
		reset_n        = 1'b0;
		five_ep_mode   = 1'b0;
		pend_vector_in = 8'h00;
		dp_resume_in   = 8'h00;
		dp_se0_in      = 8'h00;
		dp_lines_in    = 8'h00;
		repeat (16) @(posedge clk);
		#1;
		reset_n = 1'b1;
		t_timer_a;
		t_rw;
		t_idx;
		t_wo;
		t_refuse;
		t_vec;
		t_five;
		t_timer_b;
		final_report;
	end
endmodule : test_io_register_space_decode
